// ==== lfcsc_ctrl.sv ====
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Status shows active source and running state
// - Start task copies select source into snapshot
// - Select field picks internal, crystal, synthesized
// - Bypass bit for rail-to-rail external clock
// - External bit replaces crystal; needs crystal code
// - Calibration interval counts quarter seconds
// - Interval codes 1 to 127 usable
// - Calibration interval survives low-power clear
// - Start-seen bit set once start task fires
module lfcsc_ctrl
    import lfcsc_pkg::*;
#(
    parameter int QUARTER_CYCLES = LFCSC_QUARTER_CYCLES
)(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic start_task_i,
    input wire logic stop_task_i,
    input wire logic lowpower_clear_i,
    input wire logic osc_running_i,
    input wire logic cal_start_i,
    output lfcsc_osc_ctrl_t osc_ctrl_o,
    output logic cal_timeout_o
);
    // ========================================================
    // Reset release
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ========================================================
    // Running input synchroniser
    logic run_s1_q;
    logic run_s2_q;
    logic run_s3_q;
    logic running_q;
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_s1_q <= 1'b0;
            run_s2_q <= 1'b0;
            run_s3_q <= 1'b0;
            running_q <= 1'b0;
        end
        else
        begin
            run_s1_q <= osc_running_i;
            run_s2_q <= run_s1_q;
            run_s3_q <= run_s2_q;
            if (run_s2_q == run_s3_q)
            begin
                running_q <= run_s3_q;
            end
        end
    end

    // ========================================================
    // APB decode
    logic [LFCSC_ADDR_W-1:0] addr;
    logic access;
    logic wr_en;
    logic hit_seen;
    logic hit_stat;
    logic hit_snap;
    logic hit_sel;
    logic hit_cal;
    logic mapped;
    logic pready_q;
    assign addr = paddr_i[LFCSC_ADDR_W-1:0];
    assign access = psel_i && penable_i;
    assign wr_en = access && pready_q && pwrite_i;
    assign hit_seen = addr == LFCSC_OFS_START_SEEN;
    assign hit_stat = addr == LFCSC_OFS_STATUS;
    assign hit_snap = addr == LFCSC_OFS_SNAPSHOT;
    assign hit_sel = addr == LFCSC_OFS_SELECT;
    assign hit_cal = addr == LFCSC_OFS_CAL_IV;
    assign mapped = hit_seen || hit_stat || hit_snap || hit_sel || hit_cal;

    // ========================================================
    // Register state
    logic [1:0] sel_src_q;
    logic sel_bypass_q;
    logic sel_ext_q;
    logic [1:0] snap_src_q;
    logic start_seen_q;
    lfcsc_osc_ctrl_t active_q;
    logic [LFCSC_CAL_IV_W-1:0] cal_iv_q;
    logic sel_wr;
    assign sel_wr = wr_en && hit_sel && mapped;

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_src_q <= LFCSC_SRC_INTERNAL;
            sel_bypass_q <= 1'b0;
            sel_ext_q <= 1'b0;
        end
        else if (lowpower_clear_i)
        begin
            sel_src_q <= LFCSC_SRC_INTERNAL;
            sel_bypass_q <= 1'b0;
            sel_ext_q <= 1'b0;
        end
        else if (sel_wr)
        begin
            sel_src_q <= pwdata_i[LFCSC_SRC_LSB +: LFCSC_SRC_W];
            sel_bypass_q <= pwdata_i[LFCSC_BYPASS_BIT];
            sel_ext_q <= pwdata_i[LFCSC_EXTERNAL_BIT];
        end
    end

    // Snapshot, start flag and applied selection
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            snap_src_q <= LFCSC_SRC_INTERNAL;
            start_seen_q <= 1'b0;
            active_q <= '0;
        end
        else if (start_task_i)
        begin
            snap_src_q <= sel_src_q;
            start_seen_q <= 1'b1;
            active_q.src <= sel_src_q;
            active_q.bypass <= sel_bypass_q;
            active_q.external <= sel_ext_q;
            active_q.enable <= 1'b1;
        end
        else if (lowpower_clear_i)
        begin
            snap_src_q <= LFCSC_SRC_INTERNAL;
            start_seen_q <= 1'b0;
            active_q <= '0;
        end
        else if (stop_task_i)
        begin
            start_seen_q <= 1'b0;
            active_q.enable <= 1'b0;
        end
    end

    // Retained: only the full reset and APB writes touch it
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_iv_q <= LFCSC_CAL_IV_RST;
        end
        else if (wr_en && hit_cal)
        begin
            cal_iv_q <= pwdata_i[LFCSC_CAL_IV_W-1:0];
        end
    end

    // ========================================================
    // Read mux and APB answer
    logic [31:0] rd_seen;
    logic [31:0] rd_stat;
    logic [31:0] rd_snap;
    logic [31:0] rd_sel;
    logic [31:0] rd_cal;
    logic [31:0] rdata;
    assign rd_seen = 32'(start_seen_q) << LFCSC_SEEN_BIT;
    assign rd_stat = (32'(active_q.src) << LFCSC_SRC_LSB)
        | (32'(running_q) << LFCSC_STATE_BIT);
    assign rd_snap = 32'(snap_src_q) << LFCSC_SRC_LSB;
    assign rd_sel = (32'(sel_src_q) << LFCSC_SRC_LSB)
        | (32'(sel_bypass_q) << LFCSC_BYPASS_BIT)
        | (32'(sel_ext_q) << LFCSC_EXTERNAL_BIT);
    assign rd_cal = 32'(cal_iv_q);
    assign rdata = hit_seen ? rd_seen
        : hit_stat ? rd_stat
        : hit_snap ? rd_snap
        : hit_sel ? rd_sel
        : hit_cal ? rd_cal
        : LFCSC_RST_REG;

    logic [31:0] prdata_q;
    logic pslverr_q;
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
            prdata_q <= LFCSC_RST_REG;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= access && !pready_q;
            if (access && !pready_q)
            begin
                prdata_q <= pwrite_i ? LFCSC_RST_REG : rdata;
                pslverr_q <= !mapped;
            end
        end
    end
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign osc_ctrl_o = active_q;

    // ========================================================
    // Calibration timer
    logic [LFCSC_QUARTER_W-1:0] pre_q;
    logic [LFCSC_CAL_IV_W-1:0] quarters_q;
    logic cal_run_q;
    logic cal_timeout_q;
    logic quarter_tick;
    logic cal_ok;
    assign quarter_tick = cal_run_q
        && (pre_q == LFCSC_QUARTER_W'(QUARTER_CYCLES - 1));
    assign cal_ok = cal_iv_q != '0;
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_q <= '0;
            quarters_q <= '0;
            cal_run_q <= 1'b0;
            cal_timeout_q <= 1'b0;
        end
        else
        begin
            cal_timeout_q <= 1'b0;
            if (cal_start_i && cal_ok)
            begin
                pre_q <= '0;
                quarters_q <= cal_iv_q;
                cal_run_q <= 1'b1;
            end
            else if (lowpower_clear_i)
            begin
                cal_run_q <= 1'b0;
            end
            else if (quarter_tick)
            begin
                pre_q <= '0;
                quarters_q <= quarters_q - 1'b1;
                if (quarters_q == LFCSC_CAL_IV_W'(1))
                begin
                    cal_run_q <= 1'b0;
                    cal_timeout_q <= 1'b1;
                end
            end
            else if (cal_run_q)
            begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end
    assign cal_timeout_o = cal_timeout_q;

    // ========================================================
    // Checks
    chk_snap_capture: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) start_task_i |=> snap_src_q == $past(sel_src_q))
        else $error("snapshot not captured on start");
    chk_seen_set: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) start_task_i |=> start_seen_q)
        else $error("start flag not set");
    chk_active_hold: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) !start_task_i && !lowpower_clear_i
        |=> $stable(active_q.src))
        else $error("active source moved without start");
    chk_sel_write: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) sel_wr && !lowpower_clear_i |=>
        sel_src_q == $past(pwdata_i[LFCSC_SRC_LSB +: LFCSC_SRC_W])
        && sel_bypass_q == $past(pwdata_i[LFCSC_BYPASS_BIT])
        && sel_ext_q == $past(pwdata_i[LFCSC_EXTERNAL_BIT]))
        else $error("select write lost");
    chk_cal_retain: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) lowpower_clear_i && !(wr_en && hit_cal)
        |=> $stable(cal_iv_q))
        else $error("calibration interval lost");
    chk_stat_read: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) access && !pready_q && !pwrite_i && hit_stat
        |=> prdata_o[LFCSC_SRC_LSB +: LFCSC_SRC_W] == $past(active_q.src)
        && prdata_o[LFCSC_STATE_BIT] == $past(running_q))
        else $error("status read wrong");
    chk_cal_zero: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) cal_start_i && !cal_run_q && cal_iv_q == '0
        |=> !cal_run_q)
        else $error("timer started at code zero");
    chk_cal_load: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) cal_start_i && cal_ok |=>
        cal_run_q && quarters_q == $past(cal_iv_q))
        else $error("timer not loaded");
    chk_apb_wait: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n) access && !pready_q |=> pready_o)
        else $error("no answer after one wait");
    cov_start: cover property (@(posedge ref_clk_i) disable iff
        (!rst_n) sel_wr ##[1:20] start_task_i);
    cov_timeout: cover property (@(posedge ref_clk_i) disable iff
        (!rst_n) cal_timeout_o);
    cov_err: cover property (@(posedge ref_clk_i) disable iff
        (!rst_n) pready_o && pslverr_o);
endmodule // lfcsc_ctrl
`default_nettype wire

// ==== lfcsc_pkg.sv ====
`default_nettype none
// ============================================================
// Low-frequency clock source control: shared definitions
package lfcsc_pkg;
    // ========================================================
    // Register byte offsets
    localparam logic [11:0] LFCSC_OFS_START_SEEN = 12'h414;
    localparam logic [11:0] LFCSC_OFS_STATUS = 12'h418;
    localparam logic [11:0] LFCSC_OFS_SNAPSHOT = 12'h41c;
    localparam logic [11:0] LFCSC_OFS_SELECT = 12'h518;
    localparam logic [11:0] LFCSC_OFS_CAL_IV = 12'h538;
    localparam int LFCSC_ADDR_W = 12;

    // ========================================================
    // Field positions
    localparam int LFCSC_SEEN_BIT = 0;
    localparam int LFCSC_SRC_LSB = 0;
    localparam int LFCSC_SRC_W = 2;
    localparam int LFCSC_STATE_BIT = 16;
    localparam int LFCSC_BYPASS_BIT = 16;
    localparam int LFCSC_EXTERNAL_BIT = 17;
    localparam int LFCSC_CAL_IV_W = 7;

    // ========================================================
    // Source encodings
    localparam logic [1:0] LFCSC_SRC_INTERNAL = 2'h0;
    localparam logic [1:0] LFCSC_SRC_CRYSTAL = 2'h1;
    localparam logic [1:0] LFCSC_SRC_SYNTH = 2'h2;

    // ========================================================
    // Reset values
    localparam logic [31:0] LFCSC_RST_REG = 32'h0000_0000;
    localparam logic [6:0] LFCSC_CAL_IV_RST = 7'h00;

    // ========================================================
    // Timing
    localparam int LFCSC_CLK_MHZ = 100;
    localparam int LFCSC_QUARTER_MS = 250;
    localparam int LFCSC_QUARTER_CYCLES = LFCSC_QUARTER_MS * 1000
        * LFCSC_CLK_MHZ;
    localparam int LFCSC_QUARTER_W = 25;

    // ========================================================
    // Oscillator control bundle
    typedef struct packed {
        logic enable;
        logic external;
        logic bypass;
        logic [1:0] src;
    } lfcsc_osc_ctrl_t;
endpackage
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lfcsc_pkg::*;
;
    localparam int QC = 4;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic start = 1'b0;
    logic stop = 1'b0;
    logic lpc = 1'b0;
    logic osc_run = 1'b0;
    logic cal_go = 1'b0;
    lfcsc_osc_ctrl_t ctrl;
    logic cal_to;
    int fail_count = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    lfcsc_ctrl #(.QUARTER_CYCLES(QC)) i_dut (
        .ref_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .start_task_i(start), .stop_task_i(stop),
        .lowpower_clear_i(lpc), .osc_running_i(osc_run),
        .cal_start_i(cal_go), .osc_ctrl_o(ctrl), .cal_timeout_o(cal_to)
    );

    // ========================================================
    // Checking and bus tasks
    task automatic test_done;
        if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_ctrl(input lfcsc_osc_ctrl_t got,
                            input lfcsc_osc_ctrl_t exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= {20'h0, a};
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input logic err_exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk_word(rd, exp);
        chk_word({31'h0, err}, {31'h0, err_exp});
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        start <= (k == 0);
        stop <= (k == 1);
        lpc <= (k == 2);
        cal_go <= (k == 3);
        @(posedge clk);
        {start, stop, lpc, cal_go} <= 4'h0;
    endtask

    // ========================================================
    // Scenarios
    task automatic t_reset;
        rd_chk(LFCSC_OFS_START_SEEN, 32'h0, 1'b0);
        rd_chk(LFCSC_OFS_STATUS, 32'h0, 1'b0);
        rd_chk(LFCSC_OFS_SNAPSHOT, 32'h0, 1'b0);
        rd_chk(LFCSC_OFS_SELECT, 32'h0, 1'b0);
        rd_chk(LFCSC_OFS_CAL_IV, 32'h0, 1'b0);
        wr(LFCSC_OFS_STATUS, 32'h2);
        rd_chk(LFCSC_OFS_STATUS, 32'h0, 1'b0);
        rd_chk(12'h420, 32'h0, 1'b1);
    endtask

    task automatic t_sources;
        for (int s = 0; s < 3; s++)
        begin
            wr(LFCSC_OFS_SELECT, s);
            rd_chk(LFCSC_OFS_SELECT, s, 1'b0);
            pulse(0);
            @(posedge clk);
            chk_ctrl(ctrl, {3'b100, 2'(s)});
            rd_chk(LFCSC_OFS_SNAPSHOT, s, 1'b0);
            rd_chk(LFCSC_OFS_STATUS, s, 1'b0);
            rd_chk(LFCSC_OFS_START_SEEN, 32'h1, 1'b0);
        end
    endtask

    task automatic t_ext_hold;
        wr(LFCSC_OFS_SELECT, 32'h0003_0001);
        rd_chk(LFCSC_OFS_SELECT, 32'h0003_0001, 1'b0);
        pulse(0);
        @(posedge clk);
        chk_ctrl(ctrl, 5'b11101);
        wr(LFCSC_OFS_SELECT, 32'h2);
        chk_ctrl(ctrl, 5'b11101);
        rd_chk(LFCSC_OFS_SNAPSHOT, 32'h1, 1'b0);
        osc_run <= 1'b1;
        repeat (8) @(posedge clk);
        rd_chk(LFCSC_OFS_STATUS, 32'h0001_0001, 1'b0);
        osc_run <= 1'b0;
        repeat (8) @(posedge clk);
        rd_chk(LFCSC_OFS_STATUS, 32'h1, 1'b0);
        pulse(1);
        rd_chk(LFCSC_OFS_START_SEEN, 32'h0, 1'b0);
        chk_ctrl(ctrl, 5'b01101);
    endtask

    task automatic cal_run(input int iv, input int lo, input int hi);
        int n;
        n = 0;
        wr(LFCSC_OFS_CAL_IV, iv);
        pulse(3);
        while (cal_to !== 1'b1 && n < 600)
        begin
            @(posedge clk);
            n++;
        end
        chk_word(32'(n >= lo && n <= hi), 32'h1);
    endtask

    task automatic t_cal;
        wr(LFCSC_OFS_CAL_IV, 32'hff);
        rd_chk(LFCSC_OFS_CAL_IV, 32'h7f, 1'b0);
        cal_run(1, QC + 1, QC + 1);
        cal_run(127, 127 * QC + 1, 127 * QC + 1);
        cal_run(0, 600, 600);
        wr(LFCSC_OFS_CAL_IV, 32'h5);
        wr(LFCSC_OFS_SELECT, 32'h2);
        pulse(2);
        rd_chk(LFCSC_OFS_CAL_IV, 32'h5, 1'b0);
        rd_chk(LFCSC_OFS_SELECT, 32'h0, 1'b0);
        rd_chk(LFCSC_OFS_SNAPSHOT, 32'h0, 1'b0);
        chk_ctrl(ctrl, 5'b00000);
    endtask

    // ========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_sources();
        t_ext_hold();
        t_cal();
        test_done();
    end

    initial
    begin
        #200000;
        fail_count++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
